// ---- rtl/char_lcd_ram_access_port.sv ----
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`include "char_lcd_regs.svh"
// Byte access to display and glyph memories through one address counter.
module char_lcd_ram_access_port
	import char_lcd_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic reset_n,
	// Wishbone classic slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	// Display side.
	output logic busy_indicator,
	output logic [15:0] common_used,
	output logic [15:0] common_nonselect,
	output logic [4:0] duty_commons,
	output logic [4:0] digit_limit,
	output logic [5:0] display_shift
);
	logic step_up; // Address counter direction, one counts up.
	logic shift_en; // Display shift on display memory writes.
	logic bus_width_select; // One for byte transfers, zero for nibbles.
	logic lines_two; // Two display lines.
	logic font_tall; // Tall font.
	logic [6:0] address_counter; // Shared address counter.
	target_t target; // Memory chosen by the last address designation or cursor shift.
	phase_t phase; // Nibble phase in narrow mode.
	logic [3:0] high_nibble; // First nibble of a narrow write.
	logic [7:0] read_hold; // Byte held between the two narrow reads.
	logic prefetch_pending; // Read buffer must be refilled.
	logic [7:0] mem_rdata; // Read buffer of the memory.

	logic req; // A new bus request is taken this cycle.
	logic hit_instr; // Instruction register addressed.
	logic hit_data; // Data register addressed.
	logic hit_mode; // Mode readback register addressed.
	logic wr_lane; // Write with the low byte lane enabled.
	logic complete; // This access finishes a whole byte.
	logic [7:0] in_byte; // Byte assembled from the bus.
	cmd_t cmd; // Decoded instruction.
	logic exec_instr; // Instruction executes now.
	logic exec_write; // Data write executes now.
	logic exec_read; // Data read completes now.
	logic [7:0] status_byte; // Busy flag and address counter.
	logic [7:0] out_byte; // Byte that the current read sees.
	logic [31:0] next_dat; // Next read data word.

	// Picks the instruction from the highest set bit among bits 7, 6, 5, 4 and 2.
	function automatic cmd_t decode_cmd(input logic [7:0] b);
		cmd_t c;
		c = CMD_NONE;
		if (b[`OP_DISPLAY_DATA_RAM]) begin
			c = CMD_DISPLAY_DATA_RAM;
		end else if (b[`OP_GLYPH]) begin
			c = CMD_GLYPH;
		end else if (b[`OP_FUNC]) begin
			c = CMD_FUNC;
		end else if (b[`OP_SHIFT]) begin
			c = CMD_SHIFT;
		end else if (b[`OP_ENTRY]) begin
			c = CMD_ENTRY;
		end
		return c;
	endfunction

	// Steps the counter by one; glyph addresses wrap in six bits.
	function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
		input logic glyph);
		logic [6:0] n;
		n = up ? a + 7'h01 : a - 7'h01;
		if (glyph) begin
			n[6] = 1'b0;
		end
		return n;
	endfunction

	// Moves the display offset by one place within a line span.
	function automatic logic [5:0] move_shift(input logic [5:0] o, input logic left);
		logic [5:0] n;
		if (left) begin
			n = (o == `SHIFT_SPAN - 6'h01) ? 6'h00 : o + 6'h01;
		end else begin
			n = (o == 6'h00) ? `SHIFT_SPAN - 6'h01 : o - 6'h01;
		end
		return n;
	endfunction

	// Address decode and request qualification.
	always_comb begin
		req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		hit_instr = 1'b0;
		hit_data = 1'b0;
		hit_mode = 1'b0;
		if (wb_adr_i == `OFS_INSTR) begin
			hit_instr = 1'b1;
		end else if (wb_adr_i == `OFS_DATA) begin
			hit_data = 1'b1;
		end else if (wb_adr_i == `OFS_MODE) begin
			hit_mode = 1'b1;
		end
		wr_lane = wb_we_i & wb_sel_i[0];
	end

	// Byte assembly; narrow mode takes the upper four lines only.
	always_comb begin
		complete = bus_width_select | (phase == PHASE_LOW);
		if (bus_width_select) begin
			in_byte = wb_dat_i[7:0];
		end else begin
			in_byte = {high_nibble, wb_dat_i[7:4]};
		end
		cmd = decode_cmd(in_byte);
		exec_instr = req & hit_instr & wr_lane & complete;
		exec_write = req & hit_data & wr_lane & complete;
		exec_read = req & hit_data & ~wb_we_i & complete;
		status_byte = {1'b0, address_counter};
		status_byte[`STATUS_BUSY_BIT] = busy_indicator;
	end

	// Wishbone acknowledge, one cycle after the request, one cycle wide.
	// The ack term in req keeps a held request from being taken twice.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// Nibble phase flips on every narrow read, and every narrow write with byte lane 0 enabled, to the port registers.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			phase <= PHASE_HIGH;
		end else if (bus_width_select) begin
			phase <= PHASE_HIGH;
		end else if (req & (hit_instr | hit_data) & (~wb_we_i | wb_sel_i[0])) begin
			// Status and data share one phase, so a host must not mix them mid-byte.
			phase <= (phase == PHASE_HIGH) ? PHASE_LOW : PHASE_HIGH;
		end
	end

	// The first narrow write nibble is kept for the second access.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			high_nibble <= 4'h0;
		end else if (req & (hit_instr | hit_data) & wr_lane & (phase == PHASE_HIGH)) begin
			high_nibble <= wb_dat_i[7:4];
		end
	end

	// The whole byte is captured on the first narrow read.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			read_hold <= 8'h00;
		end else if (req & ~wb_we_i & (phase == PHASE_HIGH)) begin
			if (hit_instr) begin
				read_hold <= status_byte;
			end else if (hit_data) begin
				read_hold <= mem_rdata;
			end
		end
	end

	// Entry mode: step direction and shift enable.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			step_up <= `RST_STEP_UP;
			shift_en <= `RST_SHIFT_EN;
		end else if (exec_instr & (cmd == CMD_ENTRY)) begin
			step_up <= in_byte[`ENTRY_STEP_BIT];
			shift_en <= in_byte[`ENTRY_SHIFT_BIT];
		end
	end

	// Function set: bus width, line count and font, only by command.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bus_width_select <= `RST_WIDE;
			lines_two <= `RST_LINES;
			font_tall <= `RST_FONT;
		end else if (exec_instr & (cmd == CMD_FUNC)) begin
			bus_width_select <= in_byte[`FUNC_WIDTH_BIT];
			lines_two <= in_byte[`FUNC_LINES_BIT];
			font_tall <= in_byte[`FUNC_FONT_BIT];
		end
	end

	// Target memory follows the last address designation; a cursor shift selects the display memory.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			target <= TARGET_DISPLAY;
		end else if (exec_instr & (cmd == CMD_GLYPH)) begin
			target <= TARGET_GLYPH;
		end else if (exec_instr & (cmd == CMD_DISPLAY_DATA_RAM)) begin
			target <= TARGET_DISPLAY;
		end else if (exec_instr & (cmd == CMD_SHIFT) & ~in_byte[`SHIFT_DISP_BIT]) begin
			target <= TARGET_DISPLAY;
		end
	end

	// Address counter: loaded by address sets, stepped by accesses.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			address_counter <= `RST_AC;
		end else if (exec_instr & (cmd == CMD_GLYPH)) begin
			// Glyph addresses are six bits wide, so the top counter bit is cleared.
			address_counter <= {1'b0, in_byte[5:0]};
		end else if (exec_instr & (cmd == CMD_DISPLAY_DATA_RAM)) begin
			address_counter <= in_byte[6:0];
		end else if (exec_instr & (cmd == CMD_SHIFT) & ~in_byte[`SHIFT_DISP_BIT]) begin
			address_counter <= step_addr(address_counter, in_byte[`SHIFT_RIGHT_BIT],
				1'b0);
		end else if (exec_write | exec_read) begin
			address_counter <= step_addr(address_counter, step_up,
				target == TARGET_GLYPH);
		end
	end

	// Display offset; reads and glyph writes never move it.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			display_shift <= 6'h00;
		end else if (exec_write & shift_en & (target == TARGET_DISPLAY)) begin
			display_shift <= move_shift(display_shift, step_up);
		end else if (exec_instr & (cmd == CMD_SHIFT) & in_byte[`SHIFT_DISP_BIT]) begin
			// The display shift instruction moves the offset but never the counter.
			display_shift <= move_shift(display_shift, ~in_byte[`SHIFT_RIGHT_BIT]);
		end
	end

	// Refill of the read buffer after address sets, cursor moves and reads.
	// A write does not refill it, so a read right after a write is stale.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			prefetch_pending <= 1'b0;
		end else if (exec_read) begin
			prefetch_pending <= 1'b1;
		end else if (exec_instr & ((cmd == CMD_GLYPH) | (cmd == CMD_DISPLAY_DATA_RAM))) begin
			prefetch_pending <= 1'b1;
		end else if (exec_instr & (cmd == CMD_SHIFT) & ~in_byte[`SHIFT_DISP_BIT]) begin
			prefetch_pending <= 1'b1;
		end else begin
			// Any other cycle, a write included, leaves the buffer as it is.
			prefetch_pending <= 1'b0;
		end
	end

	// Busy while the read buffer is being refilled.
	always_comb begin
		busy_indicator = prefetch_pending;
	end

	// One memory holds both areas, the target bit on top.
	// Its read data lag the address by one cycle, which the busy pulse covers.
	char_lcd_ram #(
		.WIDTH(8),
		.ADDR_BITS(8)
	) u_ram (
		.clock(clock),
		.reset_n(reset_n),
		.write_en(exec_write),
		.write_addr({target, address_counter}),
		.write_data(in_byte),
		.read_en(prefetch_pending),
		.read_addr({target, address_counter}),
		.read_data(mem_rdata)
	);

	// Read data: whole byte in wide mode, nibbles on the upper lines in narrow mode.
	always_comb begin
		next_dat = 32'h0000_0000;
		out_byte = hit_instr ? status_byte : mem_rdata;
		if (hit_instr | hit_data) begin
			if (bus_width_select) begin
				next_dat[7:0] = out_byte;
			end else if (phase == PHASE_HIGH) begin
				next_dat[7:4] = out_byte[7:4];
			end else begin
				next_dat[7:4] = read_hold[3:0];
			end
		end else if (hit_mode) begin
			// The mode word is a readback of the settings for software.
			next_dat[`MODE_STEP_BIT] = step_up;
			next_dat[`MODE_SHIFT_BIT] = shift_en;
			next_dat[`MODE_WIDE_BIT] = bus_width_select;
			next_dat[`MODE_LINES_BIT] = lines_two;
			next_dat[`MODE_FONT_BIT] = font_tall;
			next_dat[`MODE_PHASE_BIT] = phase;
			next_dat[`MODE_TARGET_BIT] = target;
			next_dat[`MODE_COMMONS_LSB +: 5] = duty_commons;
			next_dat[`MODE_DIGITS_LSB +: 5] = digit_limit;
			next_dat[`MODE_OFFSET_LSB +: 6] = display_shift;
		end
	end

	// Read data register, loaded when a read is taken.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req & ~wb_we_i) begin
			wb_dat_o <= next_dat;
		end
	end

	// Scan mode: common count and digit capacity from lines and font.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			duty_commons <= `COMMONS_SHORT;
			digit_limit <= `DIGITS_ONE;
		end else if (lines_two) begin
			// Two lines win over the tall font, which cannot show a second line.
			duty_commons <= `COMMONS_TWO;
			digit_limit <= `DIGITS_TWO;
		end else if (font_tall) begin
			duty_commons <= `COMMONS_TALL;
			digit_limit <= `DIGITS_ONE;
		end else begin
			duty_commons <= `COMMONS_SHORT;
			digit_limit <= `DIGITS_ONE;
		end
	end

	// Commons beyond the scan count carry the non-selection waveform.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			common_used <= 16'h00ff;
			common_nonselect <= 16'hff00;
		end else begin
			for (int i = 0; i < 16; i++) begin
				common_used[i] <= (5'(i) < duty_commons);
				common_nonselect[i] <= ~(5'(i) < duty_commons);
			end
		end
	end
endmodule

// ---- rtl/char_lcd_regs.svh ----
`ifndef CHAR_LCD_REGS_SVH
`define CHAR_LCD_REGS_SVH
// Summary of operation
// - Data write stores whole byte in memory.
// - Last address-set picks write target memory; the code also selects display memory on a cursor shift.
// - Each write steps address counter by one.
// - Write shifts display only when shift enabled.
// - Data read returns byte of selected memory.
// - Set address before reading, else first invalid.
// - Back-to-back reads deliver next address data.
// - Cursor shift prepares read like address-set.
// - Read steps counter by one, never shifts.
// - Narrow mode moves bytes as two nibbles.
// - Narrow mode status read takes two cycles.
// - Narrow mode entered only by command.
// - Commons 8, 11 or 16 by mode.
// - Two lines short font, tall single line.
// - Unused commons drive non-selection waveform.
// - Five segments per digit, 8 or 16 digits.
// - Host selects line count and font height.
// - Direction bit one increments, zero decrements.
// - Shift right on decrement, left on increment.
// - Glyph memory accesses never shift display.
`define OFS_INSTR 4'h0
`define OFS_DATA 4'h4
`define OFS_MODE 4'h8
`define OP_ENTRY 3'd2
`define OP_SHIFT 3'd4
`define OP_FUNC 3'd5
`define OP_GLYPH 3'd6
`define OP_DISPLAY_DATA_RAM 3'd7
`define ENTRY_STEP_BIT 1
`define ENTRY_SHIFT_BIT 0
`define SHIFT_DISP_BIT 3
`define SHIFT_RIGHT_BIT 2
`define FUNC_WIDTH_BIT 4
`define FUNC_LINES_BIT 3
`define FUNC_FONT_BIT 2
`define STATUS_BUSY_BIT 7
`define RST_STEP_UP 1'b1
`define RST_SHIFT_EN 1'b0
`define RST_WIDE 1'b1
`define RST_LINES 1'b0
`define RST_FONT 1'b0
`define RST_AC 7'h00
`define COMMONS_SHORT 5'h08
`define COMMONS_TALL 5'h0b
`define COMMONS_TWO 5'h10
`define DIGITS_ONE 5'h08
`define DIGITS_TWO 5'h10
`define SHIFT_SPAN 6'h28
`define MODE_STEP_BIT 0
`define MODE_SHIFT_BIT 1
`define MODE_WIDE_BIT 2
`define MODE_LINES_BIT 3
`define MODE_FONT_BIT 4
`define MODE_PHASE_BIT 5
`define MODE_TARGET_BIT 6
`define MODE_COMMONS_LSB 8
`define MODE_DIGITS_LSB 16
`define MODE_OFFSET_LSB 24
`endif

// ---- rtl/char_lcd_pkg.sv ----
package char_lcd_pkg;
	// Which half of a byte the next narrow access carries.
	typedef enum logic {PHASE_HIGH = 1'b0, PHASE_LOW = 1'b1} phase_t;
	// Memory that data accesses reach.
	typedef enum logic {TARGET_DISPLAY = 1'b0, TARGET_GLYPH = 1'b1} target_t;
	// Instructions that this block acts on.
	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_ENTRY = 3'b001,
		CMD_SHIFT = 3'b010,
		CMD_FUNC = 3'b011,
		CMD_GLYPH = 3'b100,
		CMD_DISPLAY_DATA_RAM = 3'b101
	} cmd_t;
endpackage

// ---- rtl/char_lcd_ram.sv ----
`timescale 1ns/1ns
// Simple dual-port memory with a registered read port.
module char_lcd_ram #(
	parameter int WIDTH = 8,
	parameter int ADDR_BITS = 8
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset_n,
	// Write port.
	input wire logic write_en,
	input wire logic [ADDR_BITS-1:0] write_addr,
	input wire logic [WIDTH-1:0] write_data,
	// Read port.
	input wire logic read_en,
	input wire logic [ADDR_BITS-1:0] read_addr,
	output logic [WIDTH-1:0] read_data
);
	logic [WIDTH-1:0] mem [0:(1<<ADDR_BITS)-1]; // Storage array, not reset.

	// Writes land on the rising edge.
	always_ff @(posedge clock) begin
		if (write_en) begin
			mem[write_addr] <= write_data;
		end
	end

	// Read data is held in a register until the next read.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			read_data <= '0;
		end else if (read_en) begin
			read_data <= mem[read_addr];
		end
	end
endmodule

// ---- tb/char_lcd_port_properties.sv ----
`timescale 1ns/1ns
// Watches the port for bus timing and display mode consistency.
module char_lcd_port_properties (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset_n,
	// Bus.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// Display side.
	input wire logic busy_indicator,
	input wire logic [15:0] common_used,
	input wire logic [15:0] common_nonselect,
	input wire logic [4:0] duty_commons,
	input wire logic [4:0] digit_limit,
	input wire logic [5:0] display_shift
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// A request that has not been answered yet.
	wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Offset of the display shift one cycle ago.
	logic [5:0] prev_shift;
	// The two legal neighbours of the previous offset, modulo forty.
	wire logic [5:0] up_shift = (prev_shift == 6'h27) ? 6'h00 : prev_shift + 6'h01;
	wire logic [5:0] down_shift = (prev_shift == 6'h00) ? 6'h27 : prev_shift - 6'h01;
	// Remembers the offset so that a change can be judged.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			prev_shift <= 6'h00;
		end else begin
			prev_shift <= display_shift;
		end
	end
	a_ack_follows: assert property (req |=> wb_ack_o)
		else $error("request was not answered in the next cycle");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack stood for more than one cycle");
	a_ack_caused: assert property (wb_ack_o |-> $past(req))
		else $error("ack without a request");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i &&
		(wb_adr_i[1:0] != 2'h0 || wb_adr_i[3:2] == 2'h3) |-> wb_dat_o == 32'h0)
		else $error("unmapped read returned nonzero");
	a_duty_legal: assert property (duty_commons inside {5'h08, 5'h0b, 5'h10})
		else $error("illegal number of commons");
	a_mask_width: assert property (common_used ==
		16'((17'h1 << $past(duty_commons)) - 17'h1))
		else $error("scanned commons do not match the duty");
	a_unused_idle: assert property (common_nonselect == ~common_used)
		else $error("unused commons not driven with non-selection");
	a_digits_mode: assert property (digit_limit ==
		((duty_commons == 5'h10) ? 5'h10 : 5'h08))
		else $error("digit count does not match the line mode");
	a_shift_step: assert property ($changed(display_shift) |->
		display_shift == up_shift || display_shift == down_shift)
		else $error("display shift moved by more than one");
	a_shift_on_write: assert property ($changed(display_shift) |->
		$past(wb_we_i && req) || $past(wb_we_i && req, 2))
		else $error("display shifted without a write");
	a_busy_brief: assert property (busy_indicator |=> !busy_indicator)
		else $error("busy stood for more than one cycle");
	a_busy_cause: assert property (busy_indicator |->
		$past(req && (wb_adr_i == 4'h0 || wb_adr_i == 4'h4)))
		else $error("busy without a port access");
	c_write: cover property (req && wb_we_i);
	c_shift: cover property ($changed(display_shift));
	c_tall: cover property (duty_commons == 5'h0b);
endmodule

bind char_lcd_ram_access_port char_lcd_port_properties char_lcd_port_properties_inst (
	.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .busy_indicator(busy_indicator),
	.common_used(common_used), .common_nonselect(common_nonselect),
	.duty_commons(duty_commons), .digit_limit(digit_limit), .display_shift(display_shift));

// ---- tb/char_lcd_host_model.sv ----
`timescale 1ns/1ns
// Host processor port that makes single classic bus cycles.
module char_lcd_host_model (
	// Clock.
	input wire logic clock,
	// Bus answer.
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// Bus request.
	output logic wb_cyc_i,
	output logic wb_stb_i,
	output logic wb_we_i,
	output logic [3:0] wb_adr_i,
	output logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_i
);
	// The bus is idle at time zero.
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
	end
	// One request held until ack is sampled, then released with its data inverted.
	// Narrow bytes are handed in as two calls, high nibble first on bits 7 to 4.
	task automatic xfer(input logic [3:0] a, input logic w, input logic [7:0] d,
		input logic [3:0] s, output logic [31:0] q);
		@(posedge clock);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= {24'h0, d};
		do @(posedge clock); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
		wb_adr_i <= ~a;
		wb_dat_i <= ~wb_dat_i;
	endtask
endmodule

// ---- tb/char_lcd_ram_access_port_tb_top.sv ----
`timescale 1ns/1ns
// Drives data and instruction traffic and compares against expected results.
module char_lcd_ram_access_port_tb_top;
	// Clock and reset.
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	// Bus wires.
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	// Display side.
	logic busy_indicator;
	logic [15:0] common_used, common_nonselect;
	logic [4:0] duty_commons, digit_limit;
	logic [5:0] display_shift;
	int fail_count = 0;
	int checks = 0;
	// Refill pulses seen on the busy output, and a mark to count from.
	int busy_pulses = 0;
	int busy_mark = 0;
	// Clock of 4 ns period.
	always #2 clock = ~clock;
	// Counts each cycle in which the read buffer refill shows as busy.
	always @(posedge clock) begin
		if (busy_indicator === 1'b1) begin
			busy_pulses <= busy_pulses + 1;
		end
	end
	char_lcd_ram_access_port char_lcd_ram_access_port_inst (.clock(clock), .reset_n(reset_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
		.busy_indicator(busy_indicator), .common_used(common_used),
		.common_nonselect(common_nonselect), .duty_commons(duty_commons),
		.digit_limit(digit_limit), .display_shift(display_shift));
	char_lcd_host_model char_lcd_host_model_inst (.clock(clock), .wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i));
	// Compares one value and counts it.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Full byte write.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		char_lcd_host_model_inst.xfer(a, 1'b1, d, 4'hf, q);
	endtask
	// Read and compare the masked result.
	task automatic rc(input string name, input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] e);
		char_lcd_host_model_inst.xfer(a, 1'b0, 8'h00, 4'hf, q);
		check(name, q & m, e);
	endtask
	// Lets registered display outputs catch up.
	task automatic settle();
		repeat (3) @(posedge clock);
		#1;
	endtask
	// Function set and the resulting scan mode.
	task automatic fs(input logic [7:0] c, input logic [4:0] d, input logic [15:0] u,
		input logic [4:0] g);
		wr(4'h0, c);
		settle();
		check("duty", {27'h0, duty_commons}, {27'h0, d});
		check("used", {16'h0, common_used}, {16'h0, u});
		check("nonsel", {16'h0, common_nonselect}, {16'h0, ~u});
		check("digits", {27'h0, digit_limit}, {27'h0, g});
	endtask
	// Prints counts and verdict, then stops.
	task automatic end_of_test();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Cuts a hang short.
	initial begin
		#20000;
		fail_count++;
		end_of_test();
	end
	// Main sequence.
	initial begin
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		rc("mode", 4'h8, 32'hffffffff, 32'h00080805);
		wr(4'h0, 8'h90);
		wr(4'h4, 8'ha5);
		wr(4'h4, 8'h3c);
		rc("ac", 4'h0, 32'hff, 32'h12);
		busy_mark = busy_pulses;
		wr(4'h0, 8'h90);
		rc("data", 4'h4, 32'hff, 32'ha5);
		rc("data", 4'h4, 32'hff, 32'h3c);
		rc("ac", 4'h0, 32'hff, 32'h12);
		check("busy", busy_pulses - busy_mark, 32'h3);
		wr(4'h0, 8'h90);
		wr(4'h0, 8'h14);
		rc("cursor", 4'h4, 32'hff, 32'h3c);
		char_lcd_host_model_inst.xfer(4'h0, 1'b1, 8'h90, 4'he, q);
		rc("ac", 4'h0, 32'hff, 32'h12);
		wr(4'h0, 8'h04);
		wr(4'h0, 8'ha0);
		wr(4'h4, 8'h11);
		rc("ac", 4'h0, 32'hff, 32'h1f);
		wr(4'h0, 8'h07);
		wr(4'h0, 8'ha0);
		wr(4'h4, 8'h22);
		settle();
		check("shift", {26'h0, display_shift}, 32'h1);
		wr(4'h0, 8'h05);
		wr(4'h4, 8'h33);
		settle();
		check("shift", {26'h0, display_shift}, 32'h0);
		wr(4'h0, 8'h45);
		wr(4'h4, 8'h1f);
		settle();
		check("shift", {26'h0, display_shift}, 32'h0);
		rc("target", 4'h8, 32'h40, 32'h40);
		wr(4'h0, 8'h45);
		rc("glyph", 4'h4, 32'hff, 32'h1f);
		rc("ac", 4'h0, 32'hff, 32'h04);
		wr(4'h0, 8'h07);
		wr(4'h0, 8'ha0);
		rc("data", 4'h4, 32'hff, 32'h22);
		settle();
		check("shift", {26'h0, display_shift}, 32'h0);
		wr(4'h0, 8'h18);
		settle();
		check("shift", {26'h0, display_shift}, 32'h1);
		rc("ac", 4'h0, 32'hff, 32'h21);
		wr(4'h0, 8'h1c);
		settle();
		check("shift", {26'h0, display_shift}, 32'h0);
		fs(8'h30, 5'h08, 16'h00ff, 5'h08);
		fs(8'h34, 5'h0b, 16'h07ff, 5'h08);
		fs(8'h38, 5'h10, 16'hffff, 5'h10);
		fs(8'h3c, 5'h10, 16'hffff, 5'h10);
		fs(8'h20, 5'h08, 16'h00ff, 5'h08);
		rc("wide", 4'h8, 32'h4, 32'h0);
		wr(4'h0, 8'h20);
		fs(8'h80, 5'h10, 16'hffff, 5'h10);
		wr(4'h0, 8'h90);
		wr(4'h0, 8'h00);
		rc("high", 4'h4, 32'hf0, 32'ha0);
		rc("low", 4'h4, 32'hf0, 32'h50);
		wr(4'h4, 8'h60);
		wr(4'h4, 8'h70);
		rc("st_high", 4'h0, 32'hf0, 32'h10);
		rc("st_low", 4'h0, 32'hf0, 32'h20);
		rc("unmapped", 4'hc, 32'hffffffff, 32'h0);
		end_of_test();
	end
endmodule
